// File: verilog/wim_pkg.sv
/*
 Constants, register map and state type of the wake-up / interrupt unit.
 Assumes an 8-bit register port with offsets 0xF9..0xFF.
*/
package wim_pkg;
  localparam int WIM_LINES = 16;
  localparam logic [7:0] WIM_OFF_CTRL = 8'hF9;
  localparam logic [7:0] WIM_OFF_MASK_HI = 8'hFA;
  localparam logic [7:0] WIM_OFF_MASK_LO = 8'hFB;
  localparam logic [7:0] WIM_OFF_POL_HI = 8'hFC;
  localparam logic [7:0] WIM_OFF_POL_LO = 8'hFD;
  localparam logic [7:0] WIM_OFF_PEND_HI = 8'hFE;
  localparam logic [7:0] WIM_OFF_PEND_LO = 8'hFF;
  // control field positions
  localparam int WIM_BIT_STOP = 2;
  localparam int WIM_BIT_SRC = 1;
  localparam int WIM_BIT_WAKE = 0;
  localparam logic [7:0] WIM_RST_REG = 8'h00;
  localparam logic [15:0] WIM_RST_LINES = 16'h0000;
  typedef enum logic [1:0] {
    WIM_ST_IDLE = 2'b00,
    WIM_ST_GOT1 = 2'b01,
    WIM_ST_GOT0 = 2'b10,
    WIM_ST_ARMED = 2'b11
  } wim_state_t;
endpackage

// File: verilog/wim_unit.sv
/*
 Wake-up and interrupt manager: line edge detection, pending, mask
 and polarity registers, shared channel routing and the guarded stop
 write sequence.
 Assumes a single-cycle register port on clk_sys, a clock unit that
 reports STOP mode on stop_mode_i, and other_reg_wr pulsing for any
 register write done elsewhere in the device (interrupts, DMA).
*/
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module wim_unit #(
  parameter int NUM_LINES = wim_pkg::WIM_LINES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // writes elsewhere in the device
  input wire logic other_reg_wr,
  // pins, asynchronous
  input wire logic [NUM_LINES-1:0] wake_line_i,
  input wire logic nmi_pin_i,
  input wire logic ext_irq_pin_seven,
  input wire logic ext_stop_n,
  // clock_reset_unit side
  input wire logic stop_mode_i,
  output logic stop_req_o,
  output logic wake_req_o,
  // interrupt arbiter side
  output logic shared_irq_channel
);
  import wim_pkg::*;

  if (NUM_LINES != 16) begin : g_chk
    $error("wim_unit: register map serves exactly 16 lines");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // synchronisers: lines, nmi, pin seven, stop pin
  localparam int NS = NUM_LINES + 3;
  // stop pin bit resets high so release raises no false stop request
  localparam logic [NS-1:0] SY_RST = {1'b1, {(NS-1){1'b0}}};
  logic [NS-1:0] sy1_q;
  logic [NS-1:0] sy2_q;
  logic [NS-1:0] syp_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sy1_q <= SY_RST;
      sy2_q <= SY_RST;
    end else begin
      sy1_q <= {ext_stop_n, ext_irq_pin_seven, nmi_pin_i, wake_line_i};
      sy2_q <= sy1_q;
    end
  end
  // stop pin idles high; prev copy seeds edge detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syp_q <= SY_RST;
    end else begin
      syp_q <= sy2_q;
    end
  end

  logic [NUM_LINES-1:0] line_s;
  logic [NUM_LINES-1:0] line_p;
  logic nmi_s;
  logic nmi_rise;
  logic ext_irq_pin_seven_s;
  logic ext_stop_s;
  assign line_s = sy2_q[NUM_LINES-1:0];
  assign line_p = syp_q[NUM_LINES-1:0];
  assign nmi_s = sy2_q[NUM_LINES];
  assign nmi_rise = sy2_q[NUM_LINES] & ~syp_q[NUM_LINES];
  assign ext_irq_pin_seven_s = sy2_q[NUM_LINES+1];
  assign ext_stop_s = sy2_q[NUM_LINES+2];

  // register decode
  logic ctrl_wr;
  logic pol_wr;
  logic pend_wr_hi;
  logic pend_wr_lo;
  logic pend_wr;
  assign ctrl_wr = reg_wr & hit(reg_addr, WIM_OFF_CTRL);
  assign pol_wr = reg_wr & (hit(reg_addr, WIM_OFF_POL_HI) |
                            hit(reg_addr, WIM_OFF_POL_LO));
  assign pend_wr_hi = reg_wr & hit(reg_addr, WIM_OFF_PEND_HI);
  assign pend_wr_lo = reg_wr & hit(reg_addr, WIM_OFF_PEND_LO);
  assign pend_wr = pend_wr_hi | pend_wr_lo;

  logic src_sel_q;
  logic wake_fn_q;
  logic stop_q;
  logic [15:0] mask_q;
  logic [15:0] pol_q;
  logic [15:0] pend_q;
  logic [15:0] pend_d;
  logic [NUM_LINES-1:0] hw_set;
  wim_state_t st_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_sel_q <= 1'b0;
      wake_fn_q <= 1'b0;
    end else if (ctrl_wr) begin
      src_sel_q <= reg_wdata[WIM_BIT_SRC];
      wake_fn_q <= reg_wdata[WIM_BIT_WAKE];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_q <= WIM_RST_LINES;
      pol_q <= WIM_RST_LINES;
    end else if (reg_wr) begin
      if (hit(reg_addr, WIM_OFF_MASK_HI)) begin
        mask_q[15:8] <= reg_wdata;
      end else if (hit(reg_addr, WIM_OFF_MASK_LO)) begin
        mask_q[7:0] <= reg_wdata;
      end else if (hit(reg_addr, WIM_OFF_POL_HI)) begin
        pol_q[15:8] <= reg_wdata;
      end else if (hit(reg_addr, WIM_OFF_POL_LO)) begin
        pol_q[7:0] <= reg_wdata;
      end
    end
  end

  // per-line edge detect on the synchronised level
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_edge
    assign hw_set[i] = ~pol_wr & (pol_q[i] ? (line_s[i] & ~line_p[i])
                                           : (~line_s[i] & line_p[i]));
  end

  // a hardware set always wins over a software clear
  always_comb begin
    pend_d = pend_q;
    if (pend_wr_hi) begin
      pend_d[15:8] = reg_wdata;
    end
    if (pend_wr_lo) begin
      pend_d[7:0] = reg_wdata;
    end
    pend_d = pend_d | hw_set;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_q <= WIM_RST_LINES;
    end else begin
      pend_q <= pend_d;
    end
  end

  // routing
  logic [15:0] active;
  logic any_active;
  logic wake_evt;
  logic accept;
  assign active = mask_q & pend_q;
  assign any_active = |active;
  assign wake_evt = wake_fn_q & any_active;
  assign accept = ~nmi_s & wake_fn_q & ~any_active & (|mask_q);

  // channel drops for one cycle on a clear so the arbiter sees an edge
  logic chan_clr;
  assign chan_clr = src_sel_q & pend_wr & (|(active & ~pend_d));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shared_irq_channel <= 1'b0;
    end else begin
      shared_irq_channel <= (src_sel_q ? any_active : ext_irq_pin_seven_s)
                            & ~chan_clr;
    end
  end

  // stop sequence
  logic abort;
  logic wr_any;
  logic seq_third;
  assign wr_any = reg_wr | other_reg_wr;
  assign abort = other_reg_wr | (reg_wr & ~ctrl_wr);
  assign seq_third = (st_q == WIM_ST_GOT0) & ctrl_wr & ~other_reg_wr
                     & reg_wdata[WIM_BIT_STOP];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= WIM_ST_IDLE;
    end else begin
      case (st_q)
        WIM_ST_IDLE: begin
          if (ctrl_wr & ~other_reg_wr & reg_wdata[WIM_BIT_STOP]) begin
            st_q <= WIM_ST_GOT1;
          end
        end
        WIM_ST_GOT1: begin
          if (abort) begin
            st_q <= WIM_ST_IDLE;
          end else if (ctrl_wr & ~reg_wdata[WIM_BIT_STOP]) begin
            st_q <= WIM_ST_GOT0;
          end
        end
        WIM_ST_GOT0: begin
          if (seq_third & accept) begin
            st_q <= WIM_ST_ARMED;
          end else if (wr_any) begin
            // idle cycles keep the sequence; any write ends it
            st_q <= WIM_ST_IDLE;
          end
        end
        WIM_ST_ARMED: begin
          // a write before the clock unit reacts cancels entry
          if (wr_any | stop_mode_i) begin
            st_q <= WIM_ST_IDLE;
          end
        end
        default: st_q <= WIM_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stop_q <= 1'b0;
    end else if (seq_third) begin
      stop_q <= accept | nmi_s;
    end else if (ctrl_wr) begin
      stop_q <= reg_wdata[WIM_BIT_STOP];
    end else if (stop_mode_i & wake_evt) begin
      stop_q <= 1'b0;
    end
  end // nmi exit never touches stop_q

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stop_req_o <= 1'b0;
    end else begin
      stop_req_o <= ((st_q == WIM_ST_ARMED) & ~wr_any) | ~ext_stop_s;
    end
  end

  // clocked wake plus a clockless term for when the clock is halted
  logic wake_clk_q;
  logic [NUM_LINES-1:0] lvl_hit;
  assign lvl_hit = mask_q & ~(wake_line_i ^ pol_q);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_clk_q <= 1'b0;
    end else begin
      wake_clk_q <= wake_evt | nmi_rise;
    end
  end
  assign wake_req_o = wake_clk_q | (stop_mode_i &
                      ((wake_fn_q & (|lvl_hit)) | nmi_pin_i));

  // read data, one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= WIM_RST_REG;
    end else if (reg_rd) begin
      if (hit(reg_addr, WIM_OFF_CTRL)) begin
        reg_rdata <= {5'h00, stop_q, src_sel_q, wake_fn_q};
      end else if (hit(reg_addr, WIM_OFF_MASK_HI)) begin
        reg_rdata <= mask_q[15:8];
      end else if (hit(reg_addr, WIM_OFF_MASK_LO)) begin
        reg_rdata <= mask_q[7:0];
      end else if (hit(reg_addr, WIM_OFF_POL_HI)) begin
        reg_rdata <= pol_q[15:8];
      end else if (hit(reg_addr, WIM_OFF_POL_LO)) begin
        reg_rdata <= pol_q[7:0];
      end else if (hit(reg_addr, WIM_OFF_PEND_HI)) begin
        reg_rdata <= pend_q[15:8];
      end else if (hit(reg_addr, WIM_OFF_PEND_LO)) begin
        reg_rdata <= pend_q[7:0];
      end else begin
        reg_rdata <= WIM_RST_REG;
      end
    end else begin
      reg_rdata <= WIM_RST_REG;
    end
  end

  AST_STOP_PIN: assert property (@(posedge clk_sys) disable iff (rst)
    !ext_stop_s |=> stop_req_o)
    else $error("stop pin low did not request stop");
  AST_MASKED_QUIET: assert property (@(posedge clk_sys)
    disable iff (rst) (mask_q == 16'h0000) |=> !wake_clk_q || $past(nmi_rise))
    else $error("masked lines produced a wake event");
  AST_RISE_SETS: assert property (@(posedge clk_sys) disable iff (rst)
    (line_s[0] && !line_p[0] && pol_q[0] && !pol_wr) |=> pend_q[0])
    else $error("rising edge did not set pending");
  AST_POL_WR_DROP: assert property (@(posedge clk_sys)
    disable iff (rst) (pol_wr && !pend_wr) |=> pend_q == $past(pend_q))
    else $error("edge during polarity write set pending");
  AST_NO_HW_CLEAR: assert property (@(posedge clk_sys)
    disable iff (rst) !pend_wr |=> (($past(pend_q) & ~pend_q) == 16'h0000))
    else $error("hardware cleared a pending bit");
  AST_SW_SET: assert property (@(posedge clk_sys) disable iff (rst)
    (pend_wr_lo && reg_wdata[0]) |=> pend_q[0])
    else $error("software write of one did not set pending");
  AST_PIN7_ROUTE: assert property (@(posedge clk_sys)
    disable iff (rst) !src_sel_q |=> shared_irq_channel == $past(ext_irq_pin_seven_s))
    else $error("channel does not follow pin seven");
  AST_FRESH_EDGE: assert property (@(posedge clk_sys)
    disable iff (rst) chan_clr |=> !shared_irq_channel ##1
    (shared_irq_channel || !src_sel_q || $past(pend_wr) || !any_active))
    else $error("no fresh edge after pending clear");
  AST_SEQ_OK: assert property (@(posedge clk_sys) disable iff (rst)
    (seq_third && accept) |=> stop_q && st_q == WIM_ST_ARMED)
    else $error("accepted sequence did not arm stop");
  AST_SEQ_REFUSED: assert property (@(posedge clk_sys)
    disable iff (rst) (seq_third && !accept && !nmi_s) |=>
    !stop_q && st_q == WIM_ST_IDLE)
    else $error("refused sequence left stop bit set");
  AST_NMI_REFUSED: assert property (@(posedge clk_sys)
    disable iff (rst) (seq_third && nmi_s) |=> stop_q ##1 !stop_req_o ||
    !ext_stop_s || !$past(ext_stop_s))
    else $error("nmi refusal wrong");
  AST_WAKE_CLEARS: assert property (@(posedge clk_sys)
    disable iff (rst) (stop_mode_i && wake_evt && !ctrl_wr) |=> !stop_q)
    else $error("wake event in stop left stop bit");
  AST_FIRST_WRITE: assert property (@(posedge clk_sys)
    disable iff (rst) (st_q == WIM_ST_IDLE && ctrl_wr && !other_reg_wr &&
    reg_wdata[WIM_BIT_STOP]) |=> stop_q && st_q == WIM_ST_GOT1)
    else $error("first write did not show stop bit");
  AST_ABORT: assert property (@(posedge clk_sys) disable iff (rst)
    ((st_q == WIM_ST_GOT1 || st_q == WIM_ST_GOT0) && abort) |=>
    st_q == WIM_ST_IDLE)
    else $error("foreign write did not abort sequence");
  AST_CTRL_RSVD: assert property (@(posedge clk_sys)
    disable iff (rst) (reg_rd && hit(reg_addr, WIM_OFF_CTRL)) |=>
    reg_rdata[7:3] == 5'h00)
    else $error("reserved control bits not zero");
endmodule // wim_unit

// File: test/wim_clk_model.sv
/*
 Clock unit stand-in: enters STOP after a set delay, leaves it a few
 cycles after a wake request, keeps the stop-exit flag.
 Assumes the unit's stop and wake requests arrive on clk_sys.
*/
`timescale 1ns/1ps
module wim_clk_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bench controls
  input wire logic [2:0] entry_dly,
  input wire logic flag_clr,
  // unit side
  input wire logic stop_req,
  input wire logic wake_req,
  output logic stop_mode,
  output logic stop_exit_flag
);
  logic [2:0] cnt_q;
  // exit delay stands for the oscillator restart
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'h0;
      stop_mode <= 1'b0;
    end else if (stop_mode) begin
      if (cnt_q == 3'h6) begin
        cnt_q <= 3'h0;
        stop_mode <= 1'b0;
      end else if (wake_req || cnt_q != 3'h0) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end else if (!stop_req) begin
      cnt_q <= 3'h0;
    end else if (cnt_q == entry_dly) begin
      cnt_q <= 3'h0;
      stop_mode <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stop_exit_flag <= 1'b0;
    end else if (stop_mode && cnt_q == 3'h6) begin
      stop_exit_flag <= 1'b1;
    end else if (flag_clr) begin
      stop_exit_flag <= 1'b0;
    end
  end
endmodule // wim_clk_model

// File: test/tb.sv
/*
 Self-checking bench: register map, edge capture, channel routing and
 the guarded stop sequence of the wake-up unit.
 Assumes wim_pkg, wim_unit and wim_clk_model are compiled first.
*/
`timescale 1ns/1ps
module tb;
  import wim_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic rst_m = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic other_reg_wr = 1'b0;
  logic [15:0] wake_line_i = 16'h0000;
  logic nmi_pin_i = 1'b0;
  logic ext_irq_pin_seven = 1'b0;
  logic ext_stop_n = 1'b1;
  logic [2:0] entry_dly = 3'h3;
  logic [7:0] reg_rdata;
  logic flag_clr = 1'b0;
  logic chan_en = 1'b1;
  logic exit_flag;
  logic stop_mode_i, stop_req_o, wake_req_o, shared_irq_channel, chan_q;
  logic [15:0] pol, old, nxt;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int rises = 0;
  int r0;
  always #2 clk_sys = ~clk_sys;
  wim_unit #(.NUM_LINES(16)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .other_reg_wr(other_reg_wr),
    .wake_line_i(wake_line_i), .nmi_pin_i(nmi_pin_i),
    .ext_irq_pin_seven(ext_irq_pin_seven), .ext_stop_n(ext_stop_n),
    .stop_mode_i(stop_mode_i), .stop_req_o(stop_req_o),
    .wake_req_o(wake_req_o), .shared_irq_channel(shared_irq_channel));
  wim_clk_model i_clk (.clk_sys(clk_sys), .rst(rst_m),
    .entry_dly(entry_dly), .flag_clr(flag_clr), .stop_req(stop_req_o),
    .wake_req(wake_req_o), .stop_mode(stop_mode_i),
    .stop_exit_flag(exit_flag));
  always @(posedge clk_sys) begin
    chan_q <= shared_irq_channel;
    if (chan_en && shared_irq_channel === 1'b1 && chan_q === 1'b0) begin
      rises <= rises + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic drv(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    drv(1'b1, 1'b0, a, d);
  endtask
  // ends just past an edge so outputs have settled
  task automatic idle(input int n);
    repeat (n) drv(1'b0, 1'b0, reg_addr, reg_wdata);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    drv(1'b0, 1'b1, a, 8'h00);
    idle(1);
    chk(n, {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic rdp(input logic [15:0] e);
    rd(8'hFE, e[15:8], "pend_hi");
    rd(8'hFF, e[7:0], "pend_lo");
  endtask
  task automatic stop_seq(input logic [7:0] c);
    wr(8'hF9, c | 8'h04);
    wr(8'hF9, c);
    wr(8'hF9, c | 8'h04);
    idle(1);
  endtask
  task automatic wait_mode(input logic v);
    int n;
    n = 0;
    while (stop_mode_i !== v && n < 60) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("stop_mode", 16'(v), 16'(stop_mode_i));
  endtask
  initial begin
    void'($urandom(192));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_m <= 1'b0;
    for (int a = 8'hF9; a <= 8'hFF; a++) rd(8'(a), 8'h00, "reset");
    for (int a = 8'hFA; a <= 8'hFF; a++) begin
      nxt = 16'($urandom);
      wr(8'(a), nxt[7:0]);
      rd(8'(a), nxt[7:0], "rw");
      wr(8'(a), 8'h00);
    end
    wr(8'hF9, 8'hFA);
    wr(8'hF8, 8'hFF);
    rd(8'hF9, 8'h02, "ctrl");
    rd(8'hF8, 8'h00, "unmapped");
    $display("test registers done");
    wr(8'hF9, 8'h00);
    pol = 16'($urandom);
    wr(8'hFC, pol[15:8]);
    wr(8'hFD, pol[7:0]);
    old = 16'h0000;
    for (int i = 0; i < 7; i++) begin
      nxt = (i == 6) ? 16'h0000 : 16'($urandom);
      drv(1'b0, 1'b0, reg_addr, reg_wdata);
      wake_line_i <= nxt;
      idle(5);
      rdp((~old & nxt & pol) | (old & ~nxt & ~pol));
      wr(8'hFE, 8'h00);
      wr(8'hFF, 8'h00);
      old = nxt;
    end
    // rising edge in the cycle of a polarity write is dropped, pending stays clear
    wr(8'hFD, 8'h01);
    wake_line_i <= 16'h0001;
    drv(1'b0, 1'b0, reg_addr, reg_wdata);
    wr(8'hFD, 8'h01);
    idle(4);
    rdp(16'h0000);
    wake_line_i <= 16'h0000;
    $display("test edges done");
    wr(8'hF9, 8'h02);
    wr(8'hFB, 8'h01);
    wr(8'hFF, 8'h01);
    idle(3);
    chk("chan", 16'h0001, 16'(shared_irq_channel));
    chk("wake", 16'h0000, 16'(wake_req_o));
    wr(8'hF9, 8'h03);
    idle(3);
    chk("wake", 16'h0001, 16'(wake_req_o));
    wr(8'hFB, 8'h00);
    idle(3);
    chk("chan", 16'h0000, 16'(shared_irq_channel));
    chk("wake", 16'h0000, 16'(wake_req_o));
    wr(8'hFB, 8'h03);
    wr(8'hFF, 8'h03);
    idle(3);
    r0 = rises;
    wr(8'hFF, 8'h02);
    idle(3);
    chk("rises", 16'h0001, 16'(rises - r0));
    chan_en <= 1'b0;
    wr(8'hF9, 8'h00);
    ext_irq_pin_seven <= 1'b1;
    idle(4);
    chk("chan", 16'h0001, 16'(shared_irq_channel));
    wr(8'hFF, 8'h00);
    ext_irq_pin_seven <= 1'b0;
    idle(4);
    chk("chan", 16'h0000, 16'(shared_irq_channel));
    chan_en <= 1'b1;
    $display("test routing done");
    for (int c = 0; c < 4; c++) begin
      wr(8'hFB, (c == 1) ? 8'h00 : 8'h01);
      nmi_pin_i <= (c == 3);
      wr(8'hFF, (c == 2) ? 8'h01 : 8'h00);
      nxt[7:0] = (c == 0) ? 8'h00 : 8'h01;
      stop_seq(nxt[7:0]);
      idle(8);
      chk("stop_mode", 16'h0000, 16'(stop_mode_i));
      chk("exit_flag", 16'h0000, 16'(exit_flag));
      rd(8'hF9, nxt[7:0] | ((c == 3) ? 8'h04 : 8'h00), "ref");
      wr(8'hF9, nxt[7:0]);
    end
    nmi_pin_i <= 1'b0;
    wr(8'hFF, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wr(8'hF9, 8'h05);
      if (k == 0) wr(8'hFA, 8'h00);
      if (k == 1) begin
        drv(1'b0, 1'b0, reg_addr, reg_wdata);
        other_reg_wr <= 1'b1;
        drv(1'b0, 1'b0, reg_addr, reg_wdata);
        other_reg_wr <= 1'b0;
      end
      wr(8'hF9, 8'h01);
      wr(8'hF9, 8'h05);
      if (k == 2) wr(8'hFA, 8'h00);
      idle(8);
      chk("stop_mode", 16'h0000, 16'(stop_mode_i));
      wr(8'hF9, 8'h01);
      wr(8'hFA, 8'h00);
    end
    $display("test refusals done");
    entry_dly <= 3'h0;
    wr(8'hFD, 8'h01);
    wr(8'hF9, 8'h05);
    rd(8'hF9, 8'h05, "first");
    stop_seq(8'h01);
    wait_mode(1'b1);
    rd(8'hF9, 8'h05, "armed");
    drv(1'b0, 1'b0, reg_addr, reg_wdata);
    wake_line_i <= 16'h0001;
    idle(1);
    chk("wake", 16'h0001, 16'(wake_req_o));
    wait_mode(1'b0);
    rd(8'hF9, 8'h01, "woken");
    wake_line_i <= 16'h0000;
    wr(8'hFF, 8'h00);
    flag_clr <= 1'b1;
    entry_dly <= 3'h3;
    stop_seq(8'h01);
    wait_mode(1'b1);
    @(posedge clk_sys);
    flag_clr <= 1'b0;
    nmi_pin_i <= 1'b1;
    wait_mode(1'b0);
    rd(8'hF9, 8'h05, "nmi_wake");
    chk("exit_flag", 16'h0001, 16'(exit_flag));
    nmi_pin_i <= 1'b0;
    wr(8'hF9, 8'h01);
    wr(8'hFA, 8'h00);
    $display("test stop done");
    rst_m <= 1'b1;
    ext_stop_n <= 1'b0;
    idle(5);
    chk("stop_req", 16'h0001, 16'(stop_req_o));
    ext_stop_n <= 1'b1;
    idle(5);
    chk("stop_req", 16'h0000, 16'(stop_req_o));
    $display("test stop pin done");
    tally_and_finish();
  end
endmodule // tb
